// ### common/enc_cmp_pkg.sv
// package: constants and register field layout for the encoder output compare block
package enc_cmp_pkg;
   localparam int CNT_W = 32;                         // counter and threshold width
   localparam logic [CNT_W-1:0] THR_RESET = 32'h0000_0000;
   localparam logic             OUT_RESET = 1'b0;

   // address map of the plain register port (word index)
   localparam logic [3:0] ADDR_CTRL    = 4'h0;         // control bits
   localparam logic [3:0] ADDR_ON_THR  = 4'h1;         // switch-on threshold
   localparam logic [3:0] ADDR_OFF_THR = 4'h2;         // switch-off threshold
   localparam logic [3:0] ADDR_STATUS  = 4'h3;         // status bits

   // control field positions
   localparam int CTRL_LATCH_C   = 0;
   localparam int CTRL_LATCH_POS = 1;
   localparam int CTRL_SET_CNT   = 2;
   localparam int CTRL_LATCH_NEG = 3;
   localparam int CTRL_SET_OUT   = 4;
   localparam int CTRL_CMP_EN    = 5;
   localparam int CTRL_MEAS_EN   = 6;
   localparam int CTRL_SET_ON_C  = 7;
   localparam int CTRL_W         = 8;

   // status field positions
   localparam int STAT_OUT   = 0;
   localparam int STAT_CMPEN = 1;
   localparam int STAT_BLOCK = 2;
endpackage : enc_cmp_pkg

// ### rtl/enc_out_cmp.sv
// module: encoder driven digital output with compare and manual modes
`timescale 1ns/10ps
`default_nettype none
module enc_out_cmp (
   input  wire logic        SYS_CLK_I,    // 25 MHz system clock
   input  wire logic        NRST_I,       // synchronous reset, active low
   input  wire logic [31:0] CNT_I,        // encoder counter value
   input  wire logic        CNT_UPD_I,    // counter update strobe
   input  wire logic [3:0]  ADDR_I,       // register word index
   input  wire logic [31:0] WDATA_I,      // register write data
   input  wire logic        WR_I,         // write strobe
   input  wire logic        RD_I,         // read strobe
   output logic      [31:0] RDATA_O,      // read data, cycle after read
   output logic             OUT_O,        // 24 V output drive
   output logic             LED_GREEN_O,  // status led green
   output logic             LATCH_C_EN_O, // index latch request, gated
   output logic             LATCH_POS_O,  // external latch rising request, gated
   output logic             LATCH_NEG_O,  // external latch falling request, gated
   output logic             SET_CNT_O,    // counter preset request, gated
   output logic             SET_ON_C_O,   // preset on index latch, gated
   output logic             MEAS_EN_O     // measurement enable, gated
);

   // ==========================================================
   // register map, word index on ADDR_I
   //   word 0: control bits, read back as stored
   //     bit 0  index latch request
   //     bit 1  external latch, rising edge request
   //     bit 2  counter preset request
   //     bit 3  external latch, falling edge request
   //     bit 4  manual output level
   //     bit 5  compare enable
   //     bit 6  measurement enable
   //     bit 7  preset on index latch
   //   word 1: switch-on threshold, full counter width
   //   word 2: switch-off threshold, full counter width
   //   word 3: status, read only
   //     bit 0  output state flag
   //     bit 1  compare enable in force
   //     bit 2  other counter functions blocked
   //   other words: read as zero, writes dropped
   //
   // bus timing
   //   write taken at the edge with WR_I high, stored at once
   //   read taken at the edge with RD_I high
   //   read data stand for one cycle only, zero otherwise
   //   no wait states, strobes may run back to back
   //
   // compare timing
   //   hit evaluated on the edge that carries CNT_UPD_I
   //   output and status move at that same edge
   //   a jump over a threshold counts as reaching it
   //   last counter value kept to spot such a jump
   //
   // manual timing
   //   output follows stored bit 4 one cycle after storage
   //   so one cycle after the edge that takes the write strobe
   //
   // hazards and limits
   //   enabling compare keeps the present output level
   //   equal thresholds behave as normal order, off wins
   //   blocked request bits stay stored and readable
   //   they reach the outputs again once compare is off
   //   last counter value starts at zero after reset
   //
   // ==========================================================
   // state
   typedef struct packed {
      logic [enc_cmp_pkg::CTRL_W-1:0] ctrl;
      logic [31:0]                    on_thr;
      logic [31:0]                    off_thr;
      logic [31:0]                    prev;
      logic                           output_state_flag;
      logic [31:0]                    rdata;
   } state_t;

   state_t state_reg;
   state_t state_next;

   logic   on_hit;
   logic   off_hit;
   logic   cmp_en;
   logic   inverted;

   // ==========================================================
   // threshold detectors
   // one detector per threshold, both see the same update
   // the pair shares the last counter value
   thr_reach u_on (
      .prev_i (state_reg.prev),
      .cnt_i  (CNT_I),
      .thr_i  (state_reg.on_thr),
      .upd_i  (CNT_UPD_I),
      .hit_o  (on_hit)
   );

   thr_reach u_off (
      .prev_i (state_reg.prev),
      .cnt_i  (CNT_I),
      .thr_i  (state_reg.off_thr),
      .upd_i  (CNT_UPD_I),
      .hit_o  (off_hit)
   );

   // compare mode and threshold order
   // order flips which hit wins when both fire at once
   assign cmp_en   = state_reg.ctrl[enc_cmp_pkg::CTRL_CMP_EN];
   assign inverted = state_reg.on_thr > state_reg.off_thr;

   // ==========================================================
   // next state
   always_comb begin
      state_next = state_reg;
      if (CNT_UPD_I) begin
         state_next.prev = CNT_I;
      end
      // register writes
      if (WR_I) begin
         unique case (ADDR_I)
            enc_cmp_pkg::ADDR_CTRL:    state_next.ctrl    = WDATA_I[enc_cmp_pkg::CTRL_W-1:0];
            enc_cmp_pkg::ADDR_ON_THR:  state_next.on_thr  = WDATA_I;
            enc_cmp_pkg::ADDR_OFF_THR: state_next.off_thr = WDATA_I;
            default: ;
         endcase
      end
      // output control
      if (cmp_en) begin
         if (!inverted) begin
            if (off_hit) begin
               state_next.output_state_flag = 1'b0;
            end else if (on_hit) begin
               state_next.output_state_flag = 1'b1;
            end
         end else begin
            // inverted: window is off between off and on thresholds
            if (on_hit) begin
               state_next.output_state_flag = 1'b1;
            end else if (off_hit) begin
               state_next.output_state_flag = 1'b0;
            end
         end
      end else begin
         state_next.output_state_flag = state_reg.ctrl[enc_cmp_pkg::CTRL_SET_OUT];
      end
      // read data, valid the cycle after the strobe
      // zero outside that cycle, so a stale word never shows
      state_next.rdata = '0;
      if (RD_I) begin
         unique case (ADDR_I)
            enc_cmp_pkg::ADDR_CTRL:    state_next.rdata[enc_cmp_pkg::CTRL_W-1:0] = state_reg.ctrl;
            enc_cmp_pkg::ADDR_ON_THR:  state_next.rdata = state_reg.on_thr;
            enc_cmp_pkg::ADDR_OFF_THR: state_next.rdata = state_reg.off_thr;
            enc_cmp_pkg::ADDR_STATUS: begin
               state_next.rdata[enc_cmp_pkg::STAT_OUT]   = state_reg.output_state_flag;
               state_next.rdata[enc_cmp_pkg::STAT_CMPEN] = cmp_en;
               state_next.rdata[enc_cmp_pkg::STAT_BLOCK] = cmp_en;
            end
            default: state_next.rdata = '0;
         endcase
      end
   end

   // ==========================================================
   // registers
   // synchronous reset, every field to a constant
   // output starts inactive, led therefore off
   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
         state_reg.ctrl              <= '0;
         state_reg.on_thr            <= enc_cmp_pkg::THR_RESET;
         state_reg.off_thr           <= enc_cmp_pkg::THR_RESET;
         state_reg.prev              <= '0;
         state_reg.output_state_flag <= enc_cmp_pkg::OUT_RESET;
         state_reg.rdata             <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // outputs; other counter functions held off in compare mode
   // led is the drive itself, so the two never differ
   // gates use the stored compare bit, same cycle as storage
   assign RDATA_O      = state_reg.rdata;
   assign OUT_O        = state_reg.output_state_flag;
   assign LED_GREEN_O  = state_reg.output_state_flag;
   assign LATCH_C_EN_O = state_reg.ctrl[enc_cmp_pkg::CTRL_LATCH_C]   && !cmp_en;
   assign LATCH_POS_O  = state_reg.ctrl[enc_cmp_pkg::CTRL_LATCH_POS] && !cmp_en;
   assign LATCH_NEG_O  = state_reg.ctrl[enc_cmp_pkg::CTRL_LATCH_NEG] && !cmp_en;
   assign SET_CNT_O    = state_reg.ctrl[enc_cmp_pkg::CTRL_SET_CNT]   && !cmp_en;
   assign SET_ON_C_O   = state_reg.ctrl[enc_cmp_pkg::CTRL_SET_ON_C]  && !cmp_en;
   assign MEAS_EN_O    = state_reg.ctrl[enc_cmp_pkg::CTRL_MEAS_EN]   && !cmp_en;

endmodule : enc_out_cmp
`default_nettype wire

// ### rtl/thr_reach.sv
// module: detects that the counter reached or crossed a threshold
`timescale 1ns/10ps
`default_nettype none
module thr_reach (
   input  wire logic [31:0] prev_i,   // counter before update
   input  wire logic [31:0] cnt_i,    // counter after update
   input  wire logic [31:0] thr_i,    // threshold
   input  wire logic        upd_i,    // counter update strobe
   output logic             hit_o     // threshold reached this update
);
   // equal, or passed going up or going down
   always_comb begin
      hit_o = upd_i && ((cnt_i == thr_i) ||
              ((prev_i < thr_i) && (cnt_i > thr_i)) ||
              ((prev_i > thr_i) && (cnt_i < thr_i)));
   end
endmodule : thr_reach
`default_nettype wire

// ### verif/enc_out_cmp_props.sv
// checker: port properties of the encoder output compare block
`timescale 1ns/10ps
`default_nettype none
module enc_out_cmp_props (
   input wire logic        SYS_CLK_I, NRST_I, CNT_UPD_I, WR_I, RD_I, OUT_O, LED_GREEN_O, // clock, strobes, drive
   input wire logic        LATCH_C_EN_O, LATCH_POS_O, LATCH_NEG_O, SET_CNT_O, SET_ON_C_O, MEAS_EN_O, // requests
   input wire logic [31:0] CNT_I, WDATA_I, RDATA_O, // counter and data
   input wire logic [3:0]  ADDR_I // word index
);
   logic [31:0] on_reg, off_reg, prev_reg;
   logic        cmp_reg, set_reg;
   // shadow of thresholds, compare and manual level bits and last counter value
   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
         {on_reg, off_reg, prev_reg, cmp_reg, set_reg} <= '0;
      end else begin
         if (WR_I && ADDR_I == enc_cmp_pkg::ADDR_ON_THR) on_reg <= WDATA_I;
         if (WR_I && ADDR_I == enc_cmp_pkg::ADDR_OFF_THR) off_reg <= WDATA_I;
         if (WR_I && ADDR_I == enc_cmp_pkg::ADDR_CTRL) {cmp_reg, set_reg} <= WDATA_I[5:4];
         if (CNT_UPD_I) prev_reg <= CNT_I;
      end
   end
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!NRST_I);
   property p_led; LED_GREEN_O == OUT_O; endproperty
   a_led: assert property (p_led) else $error("led differs from drive");
   property p_gate; cmp_reg |-> !(LATCH_C_EN_O | LATCH_POS_O | LATCH_NEG_O | SET_CNT_O | SET_ON_C_O | MEAS_EN_O);
   endproperty
   a_gate: assert property (p_gate) else $error("request passed in compare mode");
   property p_on; cmp_reg && CNT_UPD_I && on_reg > off_reg && CNT_I == on_reg |=> OUT_O; endproperty
   a_on: assert property (p_on) else $error("on threshold missed");
   property p_off; cmp_reg && CNT_UPD_I && on_reg <= off_reg && CNT_I == off_reg |=> !OUT_O; endproperty
   a_off: assert property (p_off) else $error("off threshold missed");
   property p_cross; cmp_reg && CNT_UPD_I && on_reg < off_reg && prev_reg < on_reg && CNT_I > on_reg
      && CNT_I < off_reg |=> OUT_O; endproperty
   a_cross: assert property (p_cross) else $error("crossed threshold missed");
   property p_manual; !cmp_reg |=> OUT_O == $past(set_reg); endproperty
   a_manual: assert property (p_manual) else $error("drive differs from set bit");
   property p_hold; cmp_reg && !CNT_UPD_I |=> $stable(OUT_O); endproperty
   a_hold: assert property (p_hold) else $error("drive moved without update");
   property p_status; RD_I && ADDR_I == enc_cmp_pkg::ADDR_STATUS |=> RDATA_O[1:0] == {$past(cmp_reg), $past(OUT_O)};
   endproperty
   a_status: assert property (p_status) else $error("status word wrong");
endmodule : enc_out_cmp_props
bind enc_out_cmp enc_out_cmp_props enc_out_cmp_props_inst (.*);
`default_nettype wire

// ### verif/load_model.sv
// model: 24 V actuator load on the drive output
`timescale 1ns/10ps
`default_nettype none
module load_model (
   input  wire logic drv_i, // drive from block
   output logic      on_o   // load energised
);
   // resistive load follows the drive at once
   assign on_o = drv_i;
endmodule : load_model
`default_nettype wire

// ### verif/testbench.sv
// testbench: register sequences and counter updates with expected drive
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk = 1'b0, nrst = 1'b0, upd = 1'b0, wr = 1'b0, rd = 1'b0, out, led, ld, lc, lp, ln, sc, so, me;
   logic [31:0] cnt = '0, wd = '0, rdata, rv;
   logic [3:0]  addr = '0;
   int          n_fail = 0, cmp_count = 0;
   always #20 clk = ~clk;
   enc_out_cmp enc_out_cmp_inst (.SYS_CLK_I(clk), .NRST_I(nrst), .CNT_I(cnt), .CNT_UPD_I(upd), .ADDR_I(addr),
      .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .OUT_O(out), .LED_GREEN_O(led), .LATCH_C_EN_O(lc),
      .LATCH_POS_O(lp), .LATCH_NEG_O(ln), .SET_CNT_O(sc), .SET_ON_C_O(so), .MEAS_EN_O(me));
   load_model load_model_inst (.drv_i(out), .on_o(ld));
   // compare, write, read and counter update
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
      @(posedge clk) wr <= 1'b0;
      @(posedge clk) #1;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk) {rd, addr} <= {1'b1, a};
      @(posedge clk) rd <= 1'b0;
      #1 rv = rdata;
   endtask : rd_reg
   task automatic step(input logic [31:0] v, input logic e);
      @(posedge clk) {upd, cnt} <= {1'b1, v};
      @(posedge clk) upd <= 1'b0;
      #1 chk(32'({out, led, ld}), {29'h0, {3{e}}});
   endtask : step
   task automatic wrap_up;
      $display("fails %0d compares %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up
   // watchdog
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      wrap_up();
   end
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      rd_reg(enc_cmp_pkg::ADDR_STATUS);
      chk(rv, 32'h0);
      rd_reg(4'hf);
      chk(rv, 32'h0);
      wr_reg(enc_cmp_pkg::ADDR_CTRL, 32'h0000_00cf);
      chk(32'({lc, lp, ln, sc, so, me, out}), 32'h7e);
      wr_reg(enc_cmp_pkg::ADDR_CTRL, 32'h0000_0010);
      chk(32'({out, led, ld}), 32'h7);
      rd_reg(enc_cmp_pkg::ADDR_STATUS);
      chk(rv & 32'h3, 32'h1);
      wr_reg(enc_cmp_pkg::ADDR_CTRL, 32'h0000_0000);
      chk(32'({out, led, ld}), 32'h0);
      wr_reg(enc_cmp_pkg::ADDR_ON_THR, 32'h0000_000a);
      wr_reg(enc_cmp_pkg::ADDR_OFF_THR, 32'h0000_0014);
      wr_reg(enc_cmp_pkg::ADDR_CTRL, 32'h0000_00ef);
      chk(32'({lc, lp, ln, sc, so, me, out}), 32'h0);
      rd_reg(enc_cmp_pkg::ADDR_STATUS);
      chk(rv, 32'h6);
      rd_reg(enc_cmp_pkg::ADDR_ON_THR);
      chk(rv, 32'ha);
      rd_reg(enc_cmp_pkg::ADDR_CTRL);
      chk(rv, 32'hef);
      step(32'h0000_000a, 1'b1);
      step(32'h0000_0019, 1'b0);
      step(32'h0000_0005, 1'b0);
      step(32'h0000_000f, 1'b1);
      step(32'h0000_001e, 1'b0);
      wr_reg(enc_cmp_pkg::ADDR_CTRL, 32'h0000_0030);
      chk(32'(out), 32'h0);
      wr_reg(enc_cmp_pkg::ADDR_CTRL, 32'h0000_0010);
      chk(32'(out), 32'h1);
      wr_reg(enc_cmp_pkg::ADDR_ON_THR, 32'h0000_001e);
      wr_reg(enc_cmp_pkg::ADDR_OFF_THR, 32'h0000_0005);
      wr_reg(enc_cmp_pkg::ADDR_CTRL, 32'h0000_0020);
      step(32'h0000_0005, 1'b0);
      step(32'h0000_001e, 1'b1);
      step(32'h0000_000c, 1'b1);
      wr_reg(enc_cmp_pkg::ADDR_CTRL, 32'h0000_0000);
      step(32'h0000_001e, 1'b0);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
